// *** hw/dbt_debug_trace_control.sv ***
// Debug trace control block: control registers, comparators A/B/C, trace capture
// into a 64-word buffer, legacy breakpoints and CPU break requests.
// Assumes an Avalon-MM master and a CPU bus monitor synchronous to clk_sys.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
`include "dbt_params.svh"

// Behaviour
// RULE_01: While armed, only enable and arm bits accept writes.
// RULE_02: Control one ignores writes while legacy breakpoint mode is enabled.
// RULE_03: Enable bit stays clear when written while the device is secured.
// RULE_04: Arm written without enable means both bits written zero.
// RULE_05: Armed compares and stores; unarmed stops comparison and storage.
// RULE_06: Trigger select zero: address match; one: tagged before opcode executes.
// RULE_07: In debug mode trigger select replaces the legacy tag select.
// RULE_08: With break enabled, trigger select gives tagged or forced break type.
// RULE_09: Begin bit zero: trigger ends storage; one: trigger starts it.
// RULE_10: Break enable sends A/B break request when session completes.
// RULE_11: Capture field selects normal, loop, detail or profile capture.
// RULE_12: Loop capture skips redundant change-of-flow entries.
// RULE_13: Detail capture stores address and data except fetch and free cycles.
// RULE_14: Profile capture returns last executed instruction address on buffer read.
// RULE_15: Comparator C gives a third breakpoint in legacy mode.
// RULE_16: Register bits accept writes in both modes when not armed.
// RULE_17: Control one fields act only in debug mode.
// RULE_18: Buffer reads need an aligned word; others return zero, pointer kept.
// RULE_19: Count reports valid words; full flag at 64; arming clears both.
// RULE_20: Writes to buffer and count registers change nothing.
module dbt_debug_trace_control (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire dbt_pkg::dbt_avm_s avm_req,
  output logic [31:0]            avm_readdata,
  output logic                   avm_waitrequest,
  input  wire dbt_pkg::dbt_cpu_s cpu_mon,
  input  wire logic              secured,
  output logic                   debug_armed,
  output logic                   break_req,
  output logic                   break_tagged
);

  dbt_pkg::dbt_state_s st_q, st_d;

  logic                   acc, take, hit;
  logic [5:0]             idx;
  logic                   dbg, armed, legacy, prof;
  dbt_pkg::dbt_cap_e      cap;
  logic                   ma, mb, mc, ta, tb, tc, trig;
  logic                   qual, store, done;
  logic [`DBT_TB_W-1:0]   qword;
  logic                   we;
  logic [`DBT_AW-1:0]     waddr;
  logic [`DBT_TB_W-1:0]   wdat;
  logic [`DBT_TB_W-1:0]   tb_rd;
  logic [7:0]             wd;
  logic                   en_w, arm_w, tb_ok;

  // Register index from a byte address
  function automatic logic [5:0] reg_idx(input logic [7:0] a);
    return a[7:2];
  endfunction : reg_idx

  // Register read value; the trace word appears only on an aligned full-word read
  function automatic logic [31:0] rd_word(input dbt_pkg::dbt_state_s s,
                                          input logic [5:0] i,
                                          input logic ok,
                                          input logic [15:0] tb);
    logic [31:0] r;
    r = 32'h0;
    case (i)
      `DBT_IDX_CTL1: r[7:0] = s.ctl1;
      `DBT_IDX_TBH:  r[15:0] = ok ? tb : 16'h0;
      `DBT_IDX_CNT:  r[7:0] = {s.full, 1'b0, s.cnt};
      `DBT_IDX_CCX:  r[7:0] = s.ccx;
      `DBT_IDX_CCH:  r[7:0] = s.cch;
      `DBT_IDX_CCL:  r[7:0] = s.ccl;
      `DBT_IDX_CTL2: r[7:0] = s.ctl2;
      `DBT_IDX_CTL3: r[7:0] = s.ctl3;
      `DBT_IDX_CAX:  r[7:0] = s.cax;
      `DBT_IDX_CAH:  r[7:0] = s.cah;
      `DBT_IDX_CAL:  r[7:0] = s.cal;
      `DBT_IDX_CBX:  r[7:0] = s.cbx;
      `DBT_IDX_CBH:  r[7:0] = s.cbh;
      `DBT_IDX_CBL:  r[7:0] = s.cbl;
      default:       r = 32'h0;
    endcase
    return r;
  endfunction : rd_word

  // Trace buffer storage
  dbt_trace_ram #(
    .WIDTH (`DBT_TB_W),
    .DEPTH (`DBT_TB_DEPTH),
    .AW    (`DBT_AW)
  ) u_ram (
    .clk_sys (clk_sys),
    .wr_en   (we),
    .wr_addr (waddr),
    .wr_data (wdat),
    .rd_addr (st_q.rp),
    .rd_data (tb_rd)
  );

  // Next-state logic: capture first, so that a bus write in the same cycle wins
  always_comb begin
    st_d    = st_q;
    st_d.brk = 1'b0;
    idx     = reg_idx(avm_req.address);
    acc     = avm_req.read | avm_req.write;
    take    = acc & st_q.waitreq;
    hit     = acc & ~st_q.waitreq;
    legacy  = st_q.ctl2[`DBT_B_LEG];
    dbg     = st_q.ctl1[`DBT_B_EN] & ~legacy; // RULE_17
    armed   = st_q.ctl1[`DBT_B_ARM];
    cap     = dbt_pkg::dbt_cap_e'(st_q.ctl1[1:0]);
    prof    = dbg & (cap == dbt_pkg::DBT_CAP_PROFILE);
    tb_ok   = (avm_req.byteenable == `DBT_BE_WORD) & ~armed;
    wd      = avm_req.writedata[7:0];
    en_w    = 1'b0;
    arm_w   = 1'b0;
    we      = 1'b0;
    waddr   = st_q.wp;
    wdat    = 16'h0;
    done    = 1'b0;
    // Comparator matches on bus cycles and on instruction start
    ma = cpu_mon.cyc_valid & (cpu_mon.addr == {st_q.cah, st_q.cal});
    mb = cpu_mon.cyc_valid & (cpu_mon.addr == {st_q.cbh, st_q.cbl});
    mc = cpu_mon.cyc_valid & (cpu_mon.addr == {st_q.cch, st_q.ccl});
    ta = cpu_mon.exec_start & (cpu_mon.exec_addr == {st_q.cah, st_q.cal});
    tb = cpu_mon.exec_start & (cpu_mon.exec_addr == {st_q.cbh, st_q.cbl});
    tc = cpu_mon.exec_start & (cpu_mon.exec_addr == {st_q.cch, st_q.ccl});
    // Trigger select plays the legacy tag role in debug mode
    trig = dbg & armed & (st_q.ctl1[`DBT_B_TSEL] ? (ta | tb) : (ma | mb)); // RULE_06 RULE_07
    // Which bus cycles qualify for storage
    qword = cpu_mon.addr;
    case (cap)
      dbt_pkg::DBT_CAP_NORMAL: qual = cpu_mon.cyc_valid & cpu_mon.cof; // RULE_11
      dbt_pkg::DBT_CAP_LOOP:   qual = cpu_mon.cyc_valid & cpu_mon.cof
                                      & (cpu_mon.addr != st_q.last_cof); // RULE_12
      dbt_pkg::DBT_CAP_DETAIL: qual = cpu_mon.cyc_valid & ~cpu_mon.fetch
                                      & ~cpu_mon.free; // RULE_13
      default:                 qual = 1'b0;
    endcase
    store = dbg & armed & (qual | st_q.pend_v)
            & ((st_q.phase == dbt_pkg::DBT_PH_STORE)
               | ((st_q.phase == dbt_pkg::DBT_PH_WAIT) & trig)); // RULE_05 RULE_09
    // Held data word of a detail cycle goes first; a new cycle then is dropped
    if (store) begin
      we    = 1'b1;
      wdat  = st_q.pend_v ? st_q.pend : qword;
      st_d.wp  = st_q.wp + 1'b1;
      st_d.cnt = st_q.cnt + 1'b1; // RULE_19
      if (st_q.cnt == `DBT_CNT_MAX) begin
        st_d.full = 1'b1;
      end
      if (st_q.pend_v) begin
        st_d.pend_v = 1'b0;
      end else if (cap == dbt_pkg::DBT_CAP_DETAIL) begin
        st_d.pend   = cpu_mon.data; // RULE_13
        st_d.pend_v = 1'b1;
      end else if (cap == dbt_pkg::DBT_CAP_LOOP) begin
        st_d.last_cof = cpu_mon.addr; // RULE_12
      end
    end
    // Session sequencing
    case (st_q.phase)
      dbt_pkg::DBT_PH_WAIT: begin
        if (trig) begin
          st_d.phase = dbt_pkg::DBT_PH_STORE; // RULE_09
        end
      end
      dbt_pkg::DBT_PH_STORE: begin
        if (st_q.ctl1[`DBT_B_BEGIN]) begin
          done = store & (st_q.cnt == `DBT_CNT_MAX);
        end else begin
          done = trig; // RULE_09
        end
      end
      default: done = 1'b0;
    endcase
    if (!(dbg & armed)) begin
      done = 1'b0;
    end
    // Completion disarms, points the reader at the oldest word, may break
    if (done) begin
      st_d.phase = dbt_pkg::DBT_PH_IDLE;
      st_d.ctl1[`DBT_B_ARM] = 1'b0;
      st_d.rp = st_d.full ? st_d.wp : '0;
      if (st_q.ctl1[`DBT_B_BRK]) begin
        st_d.brk     = 1'b1; // RULE_10
        st_d.brk_tag = st_q.ctl1[`DBT_B_TSEL]; // RULE_08
      end
    end
    // Legacy A/B breakpoints use the legacy tag select
    if (legacy & (st_q.ctl2[`DBT_B_LTAG] ? (ta | tb) : (ma | mb))) begin
      st_d.brk     = 1'b1;
      st_d.brk_tag = st_q.ctl2[`DBT_B_LTAG];
    end
    // Comparator C break; in loop capture it is busy tracking entries
    if (st_q.ctl2[`DBT_B_CBRK] & (legacy | (dbg & (cap != dbt_pkg::DBT_CAP_LOOP)))
        & (st_q.ctl2[`DBT_B_CTAG] ? tc : mc)) begin
      st_d.brk     = 1'b1; // RULE_15
      st_d.brk_tag = st_q.ctl2[`DBT_B_CTAG];
    end
    // Last executed instruction for profile reads
    if (cpu_mon.exec_start) begin
      st_d.last_instr = cpu_mon.exec_addr;
    end
    // Bus handshake: waitrequest drops for exactly one cycle after the request
    st_d.waitreq = ~take;
    if (take) begin
      st_d.rdata = avm_req.read ? rd_word(st_q, idx, tb_ok, tb_rd) : 32'h0;
      if (avm_req.read & prof & (idx == `DBT_IDX_TBH)) begin
        st_d.rdata = {16'h0, st_q.last_instr}; // RULE_14
      end
    end
    // Trace reads advance the pointer only when the word was really delivered
    if (hit & avm_req.read & (idx == `DBT_IDX_TBH) & tb_ok & ~prof) begin
      st_d.rp = st_q.rp + 1'b1; // RULE_18
    end
    // Register writes take effect at the accepting edge
    if (hit & avm_req.write & avm_req.byteenable[0]) begin
      if (idx == `DBT_IDX_CTL1) begin
        if (!legacy) begin // RULE_02
          en_w  = wd[`DBT_B_EN] & ~secured; // RULE_03
          arm_w = wd[`DBT_B_ARM] & en_w; // RULE_04
          if (armed) begin
            st_d.ctl1 = {en_w, arm_w, st_d.ctl1[5:0]}; // RULE_01
          end else begin
            st_d.ctl1 = {en_w, arm_w, wd[5:0]} & `DBT_CTL1_MASK; // RULE_16
          end
          if (arm_w) begin
            st_d.cnt    = '0; // RULE_19
            st_d.full   = 1'b0;
            st_d.wp     = '0;
            st_d.pend_v = 1'b0;
            st_d.last_cof = 16'h0;
            st_d.phase  = st_d.ctl1[`DBT_B_BEGIN] ? dbt_pkg::DBT_PH_WAIT
                                                  : dbt_pkg::DBT_PH_STORE;
          end else begin
            st_d.phase = dbt_pkg::DBT_PH_IDLE; // RULE_05
            st_d.rp    = st_d.full ? st_d.wp : '0;
          end
        end
      end else if (!armed) begin // RULE_01
        // Buffer and count registers are read only and absent here
        case (idx) // RULE_16 RULE_20
          `DBT_IDX_CCX:  st_d.ccx  = wd;
          `DBT_IDX_CCH:  st_d.cch  = wd;
          `DBT_IDX_CCL:  st_d.ccl  = wd;
          `DBT_IDX_CTL2: st_d.ctl2 = wd;
          `DBT_IDX_CTL3: st_d.ctl3 = wd;
          `DBT_IDX_CAX:  st_d.cax  = wd;
          `DBT_IDX_CAH:  st_d.cah  = wd;
          `DBT_IDX_CAL:  st_d.cal  = wd;
          `DBT_IDX_CBX:  st_d.cbx  = wd;
          `DBT_IDX_CBH:  st_d.cbh  = wd;
          `DBT_IDX_CBL:  st_d.cbl  = wd;
          default:       st_d.ccx  = st_q.ccx;
        endcase
      end
    end
  end

  // State register; reset leaves all control bits clear and the bus stalled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q         <= '0;
      st_q.phase   <= dbt_pkg::DBT_PH_IDLE;
      st_q.waitreq <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state flops
  assign avm_readdata    = st_q.rdata;
  assign avm_waitrequest = st_q.waitreq;
  assign debug_armed     = st_q.ctl1[`DBT_B_ARM];
  assign break_req       = st_q.brk;
  assign break_tagged    = st_q.brk_tag;

  // Checks on the logic above
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_req_seen;
    acc && st_q.waitreq;
  endsequence

  sequence s_one_answer;
    !st_q.waitreq ##1 st_q.waitreq;
  endsequence

  bus_answer_a: // Bus handshake
    assert property (s_req_seen |=> s_one_answer)
    else $error("waitrequest did not drop for exactly one cycle");

  armed_lock_a: // RULE_01
    assert property (hit && avm_req.write && armed && idx == `DBT_IDX_CTL2
                     |=> $stable(st_q.ctl2))
    else $error("control two changed while armed");

  legacy_lock_a: // RULE_02
    assert property (hit && avm_req.write && legacy && idx == `DBT_IDX_CTL1
                     |=> $stable(st_q.ctl1[7:6]))
    else $error("control one written in legacy mode");

  secure_enable_a: // RULE_03
    assert property (hit && avm_req.write && secured && idx == `DBT_IDX_CTL1
                     |=> !st_q.ctl1[`DBT_B_EN])
    else $error("enable set while secured");

  arm_needs_en_a: // RULE_04
    assert property ($rose(st_q.ctl1[`DBT_B_ARM]) |-> st_q.ctl1[`DBT_B_EN]
                     && $past(hit) && $past(avm_req.writedata[`DBT_B_EN]))
    else $error("arm set without enable in the same write");

  idle_no_store_a: // RULE_05
    assert property (!armed && !(hit && avm_req.write) |=> $stable(st_q.wp))
    else $error("buffer pointer moved while unarmed");

  full_on_wrap_a: // RULE_19
    assert property (store && st_q.cnt == `DBT_CNT_MAX |=> st_q.full && st_q.cnt == '0)
    else $error("full flag not set on count wrap");

  tb_bad_read_a: // RULE_18
    assert property (take && avm_req.read && idx == `DBT_IDX_TBH && !prof
                     && avm_req.byteenable != `DBT_BE_WORD
                     |=> st_q.rdata == 32'h0 ##1 $stable(st_q.rp))
    else $error("partial trace read returned data or moved pointer");

  ro_write_a: // RULE_20
    assert property (hit && avm_req.write && !armed && idx == `DBT_IDX_CNT
                     |=> $stable(st_q.cnt) && $stable(st_q.full))
    else $error("write changed the count register");

  profile_read_a: // RULE_14
    assert property (take && avm_req.read && prof && idx == `DBT_IDX_TBH
                     |=> st_q.rdata == {16'h0, $past(st_q.last_instr)})
    else $error("profile read did not return the last instruction address");

  count_step_a: // RULE_19
    assert property (store && !(hit && avm_req.write)
                     |=> st_q.cnt == $past(st_q.cnt) + 1'b1)
    else $error("count did not follow a stored word");

endmodule : dbt_debug_trace_control

// *** hw/dbt_params.svh ***
// Constants of the debug trace control block: register indices, field positions,
// reset values and trace buffer size.
// Assumes a 32-bit Avalon-MM slave where byte address = 4 * register index.
`ifndef DBT_PARAMS_SVH
`define DBT_PARAMS_SVH

// Register indices (byte address is four times the index)
`define DBT_IDX_CTL1   6'h20
`define DBT_IDX_TBH    6'h22
`define DBT_IDX_TBL    6'h23
`define DBT_IDX_CNT    6'h24
`define DBT_IDX_CCX    6'h25
`define DBT_IDX_CCH    6'h26
`define DBT_IDX_CCL    6'h27
`define DBT_IDX_CTL2   6'h28
`define DBT_IDX_CTL3   6'h29
`define DBT_IDX_CAX    6'h2a
`define DBT_IDX_CAH    6'h2b
`define DBT_IDX_CAL    6'h2c
`define DBT_IDX_CBX    6'h2d
`define DBT_IDX_CBH    6'h2e
`define DBT_IDX_CBL    6'h2f

// Control one fields
`define DBT_B_EN       7
`define DBT_B_ARM      6
`define DBT_B_TSEL     5
`define DBT_B_BEGIN    4
`define DBT_B_BRK      3
`define DBT_CTL1_MASK  8'hfb
// Control two fields
`define DBT_B_LEG      7
`define DBT_B_LTAG     4
`define DBT_B_CBRK     3
`define DBT_B_CTAG     2
// Count register full flag position
`define DBT_B_FULL     7

// Trace buffer geometry
`define DBT_TB_DEPTH   64
`define DBT_AW         6
`define DBT_TB_W       16
`define DBT_CNT_MAX    6'h3f
`define DBT_BE_WORD    4'hf
`define DBT_REG_RST    8'h00

`endif

// *** hw/dbt_pkg.sv ***
// Types of the debug trace control block: bus and monitor carriers, modes, state.
// Widths come from dbt_params.svh, which must be compiled with this package.
`include "dbt_params.svh"
package dbt_pkg;

  // Capture mode encoding of control one bits 1:0
  typedef enum logic [1:0] {
    DBT_CAP_NORMAL  = 2'b00,
    DBT_CAP_LOOP    = 2'b01,
    DBT_CAP_DETAIL  = 2'b10,
    DBT_CAP_PROFILE = 2'b11
  } dbt_cap_e;

  // Trace session phase
  typedef enum logic [1:0] {
    DBT_PH_IDLE  = 2'b00,
    DBT_PH_WAIT  = 2'b01,
    DBT_PH_STORE = 2'b10
  } dbt_phase_e;

  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } dbt_avm_s;

  // CPU bus monitor, one bus cycle per clock when cyc_valid is high
  typedef struct packed {
    logic                 cyc_valid;
    logic [15:0]          addr;
    logic [15:0]          data;
    logic                 fetch;
    logic                 free;
    logic                 cof;
    logic                 exec_start;
    logic [15:0]          exec_addr;
  } dbt_cpu_s;

  // Whole state of the control block
  typedef struct packed {
    logic [7:0]              ctl1, ctl2, ctl3;
    logic [7:0]              cax, cah, cal, cbx, cbh, cbl, ccx, cch, ccl;
    dbt_phase_e              phase;
    logic [`DBT_AW-1:0]      wp, rp, cnt;
    logic                    full;
    logic [`DBT_TB_W-1:0]    last_cof, last_instr, pend;
    logic                    pend_v;
    logic                    waitreq;
    logic [31:0]             rdata;
    logic                    brk, brk_tag;
  } dbt_state_s;

endpackage : dbt_pkg

// *** hw/dbt_trace_ram.sv ***
// Trace buffer memory: one synchronous write port, one asynchronous read port.
// Contents are not reset; the owner tracks which words are valid.
`timescale 1ns/10ps
module dbt_trace_ram #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic             clk_sys,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read is combinational so the owner can register it with the bus answer
  assign rd_data = mem[rd_addr];

endmodule : dbt_trace_ram

// *** bench/dbt_cpu_model.sv ***
// CPU side model: plays the bus monitor cycles that the bench asks for.
// Assumes commands change just after a rising edge of clk_sys.
`timescale 1ns/10ps
module dbt_cpu_model (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              cmd_v,
  input  wire dbt_pkg::dbt_cpu_s cmd,
  output dbt_pkg::dbt_cpu_s      cpu_mon
);
  logic [15:0] pat_q;

  // Idle cycles carry a moving pattern, so a stale address never looks valid
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pat_q   <= 16'h5a5a;
      cpu_mon <= '0;
    end else begin
      pat_q <= pat_q + 16'h3b1d;
      if (cmd_v) begin
        cpu_mon <= cmd;
      end else begin
        cpu_mon <= '{1'b0, pat_q, ~pat_q, pat_q[0], pat_q[1], 1'b0, 1'b0, ~pat_q};
      end
    end
  end
endmodule : dbt_cpu_model

// *** bench/tb_debug_trace_control_regs.sv ***
// Self-checking bench of the debug trace control block.
// Assumes the CPU model on the monitor port and an Avalon-MM master here.
`timescale 1ns/10ps
module tb_debug_trace_control_regs;
  logic              clk_sys, rst, secured, cmd_v;
  logic              avm_waitrequest, debug_armed, break_req, break_tagged;
  logic [31:0]       avm_readdata;
  dbt_pkg::dbt_avm_s avm_req;
  dbt_pkg::dbt_cpu_s cmd, cpu_mon;
  int                num_errors, num_checks, seed;
  logic [31:0]       rq[$];
  logic              bq[$];
  logic [7:0]        v[64];
  logic [15:0]       ca, cb, cc, r16;
  logic [5:0]        ix[10] = '{6'h25, 6'h26, 6'h27, 6'h29, 6'h2a,
                                6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h2f};

  // Clock, 5 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  dbt_debug_trace_control dut (.clk_sys(clk_sys), .rst(rst), .avm_req(avm_req),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .cpu_mon(cpu_mon),
    .secured(secured), .debug_armed(debug_armed), .break_req(break_req),
    .break_tagged(break_tagged));
  dbt_cpu_model cpu_m (.clk_sys(clk_sys), .rst(rst), .cmd_v(cmd_v), .cmd(cmd),
    .cpu_mon(cpu_mon));

  task automatic results;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic fail(input string m);
    $display("unexpected at %0t: %s", $time, m);
    num_errors++;
  endtask : fail

  task automatic chk_rd(input logic [31:0] e);
    num_checks++;
    if (avm_readdata !== e) fail($sformatf("read %h, want %h", avm_readdata, e));
  endtask : chk_rd

  task automatic chk_brk(input logic e);
    num_checks++;
    if (break_tagged !== e) fail("break type");
  endtask : chk_brk

  task automatic chk_arm(input logic e);
    @(negedge clk_sys);
    num_checks++;
    if (debug_armed !== e) fail("armed state");
  endtask : chk_arm

  // One Avalon access, held until the rising edge that samples waitrequest low
  task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    avm_req <= '{read: r, write: !r, address: a, writedata: d, byteenable: be};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avm_waitrequest !== 1'b0 && n < 20);
    if (avm_waitrequest !== 1'b0) begin
      fail("bus timeout");
      results();
    end
    avm_req.read  <= 1'b0;
    avm_req.write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, {24'h0, d}, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [3:0] be = 4'hf);
    rq.push_back(e);
    bus(1'b1, a, 32'h0, be);
  endtask : rd

  // k is {valid, fetch, free, cof, exec_start}
  task automatic cpu(input logic [15:0] a, input logic [15:0] d, input logic [4:0] k);
    @(posedge clk_sys);
    cmd   <= '{k[4], a, d, k[3], k[2], k[1], k[0], a};
    cmd_v <= 1'b1;
  endtask : cpu

  task automatic idle(input int n);
    @(posedge clk_sys);
    cmd_v <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // Results are taken at the rising edge that ends the answer cycle
  always @(posedge clk_sys) begin
    if (avm_waitrequest === 1'b0 && avm_req.read === 1'b1) begin
      if (rq.size() == 0) fail("read without note");
      else chk_rd(rq.pop_front());
    end
    if (break_req === 1'b1) begin
      if (bq.size() == 0) fail("break without note");
      else chk_brk(bq.pop_front());
    end
  end

  // Main sequence
  initial begin
    seed = 32'he13b362a;
    num_errors = 0;
    num_checks = 0;
    avm_req = '0;
    cmd = '0;
    cmd_v = 1'b0;
    secured = 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h80, 32'h0);
    rd(8'h90, 32'h0);
    // Comparator high bytes kept apart so A, B and C never alias the traffic
    foreach (ix[i]) v[ix[i]] = 8'($random(seed));
    v[6'h26] = 8'h83;
    v[6'h2b] = 8'h81;
    v[6'h2e] = 8'h82;
    foreach (ix[i]) wr({ix[i], 2'b00}, v[ix[i]]);
    foreach (ix[i]) rd({ix[i], 2'b00}, {24'h0, v[ix[i]]});
    ca = {v[6'h2b], v[6'h2c]};
    cb = {v[6'h2e], v[6'h2f]};
    cc = {v[6'h26], v[6'h27]};
    wr(8'h84, 8'hff);
    rd(8'h84, 32'h0);
    secured <= 1'b1;
    wr(8'h80, 8'h80);
    rd(8'h80, 32'h0);
    secured <= 1'b0;
    wr(8'h80, 8'h40);
    rd(8'h80, 32'h0);
    // Legacy breakpoints: control one locked, C forced, A tagged
    wr(8'ha0, 8'h98);
    wr(8'h80, 8'h80);
    rd(8'h80, 32'h0);
    bq.push_back(1'b0);
    cpu(cc, 16'h0, 5'b10000);
    idle(4);
    bq.push_back(1'b1);
    cpu(ca, 16'h0, 5'b00001);
    idle(4);
    wr(8'ha0, 8'h00);
    // End-trigger session that overfills the buffer
    wr(8'h80, 8'hc8);
    chk_arm(1'b1);
    wr(8'ha0, 8'hff);
    wr(8'h90, 8'h55);
    rd(8'h88, 32'h0);
    for (int i = 0; i < 66; i++) cpu(16'(16'h1000 + i), 16'h0, 5'b10010);
    bq.push_back(1'b0);
    cpu(ca, 16'h0, 5'b10000);
    idle(4);
    chk_arm(1'b0);
    rd(8'h80, 32'h88);
    rd(8'h90, 32'h82);
    rd(8'ha0, 32'h0);
    rd(8'h88, 32'h1002);
    rd(8'h8c, 32'h0);
    rd(8'h88, 32'h0, 4'h3);
    rd(8'h88, 32'h1003);
    wr(8'h88, 8'h00);
    wr(8'h90, 8'hff);
    rd(8'h88, 32'h1004);
    cpu(16'h1400, 16'h0, 5'b10010);
    idle(2);
    rd(8'h90, 32'h82);
    // Begin-trigger session, ended by a disarm write
    wr(8'h80, 8'hd0);
    rd(8'h90, 32'h0);
    cpu(16'h1100, 16'h0, 5'b10010);
    cpu(16'h1101, 16'h0, 5'b10010);
    cpu(ca, 16'h0, 5'b10010);
    cpu(16'h1102, 16'h0, 5'b10010);
    cpu(16'h1103, 16'h0, 5'b10010);
    idle(2);
    wr(8'h80, 8'h80);
    rd(8'h90, 32'h3);
    rd(8'h88, {16'h0, ca});
    rd(8'h88, 32'h1102);
    // Detail capture skips fetch and free cycles
    r16 = 16'($random(seed));
    wr(8'h80, 8'hc2);
    cpu(16'h3000, 16'h1, 5'b11000);
    cpu(16'h3001, 16'h2, 5'b10100);
    cpu(16'h2222, r16, 5'b10000);
    idle(3);
    wr(8'h80, 8'h80);
    rd(8'h90, 32'h2);
    rd(8'h88, 32'h2222);
    rd(8'h88, {16'h0, r16});
    // Loop capture drops a repeated change of flow
    wr(8'h80, 8'hc1);
    cpu(16'h1200, 16'h0, 5'b10010);
    cpu(16'h1200, 16'h0, 5'b10010);
    cpu(16'h1201, 16'h0, 5'b10010);
    idle(2);
    wr(8'h80, 8'h80);
    rd(8'h90, 32'h2);
    // Profile capture returns the last executed address
    wr(8'h80, 8'h83);
    cpu(16'h4321, 16'h0, 5'b00001);
    idle(2);
    rd(8'h88, 32'h4321);
    // Tagged trigger with break enabled
    wr(8'h80, 8'he8);
    bq.push_back(1'b1);
    cpu(ca, 16'h0, 5'b00001);
    idle(4);
    chk_arm(1'b0);
    num_checks++;
    if (bq.size() != 0 || rq.size() != 0) fail("missing result");
    results();
  end
endmodule : tb_debug_trace_control_regs
